// ===== rtl/acd_cfg.svh
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH
// command byte field positions
`define ACD_CMD_MODE 6
`define ACD_CMD_PAD 5
`define ACD_CMD_KIND_HI 5
`define ACD_CMD_KIND_LO 4
`define ACD_CMD_SLEEP 3
`define ACD_CMD_RATE_HI 2
`define ACD_CMD_RS_HI 4
`define ACD_CMD_RS_LO 1
`define ACD_CMD_WR 0
// register select codes
`define ACD_SEL_STATUS 4'h0
`define ACD_SEL_CONTROL_ONE 4'h1
`define ACD_SEL_PORT_PIN_CONTROL 4'h2
`define ACD_SEL_GAIN_AND_TRIM_CONTROL 4'h3
`define ACD_SEL_DATA 4'h4
`define ACD_SEL_SOC 4'h5
`define ACD_SEL_CHIP_FULLSCALE_COEFF 4'h8
// power-on values
`define ACD_RST_CONTROL_ONE 8'h02
`define ACD_RST_PORT_PIN_CONTROL 8'h0f
`define ACD_RST_GAIN_AND_TRIM_CONTROL 8'h1e
`define ACD_RST_COEFF 24'h000000
// operation kinds and rate code used for sleep
`define ACD_KIND_CONV 2'h0
`define ACD_KIND_SYSGAIN 2'h3
`define ACD_RATE_SLEEP 3'h0
// transfer lengths in bytes
`define ACD_LEN_WIDE 2'h3
`define ACD_LEN_NARROW 2'h1
// digital gain field of control three
`define ACD_GAIN_HI 7
`define ACD_GAIN_LO 5
// two's complement clip limits of the 18-bit result
`define ACD_RES_MAX 18'h1ffff
`define ACD_RES_MIN 18'h20000
`endif

// ===== rtl/acd_pkg.sv
package acd_pkg;
  // transfer phase, gray along cmd->read and cmd->write
  typedef enum logic [1:0] {
    ACD_ST_CMD = 2'b00,
    ACD_ST_READ = 2'b01,
    ACD_ST_WRITE = 2'b10
  } acd_state_t;
endpackage

// ===== rtl/acd_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial front end: sync, edges, shifting
// ****************************************
module acd_spi_shift (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  // decoder side
  input wire logic hunt_i,
  input wire logic tx_load_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic idle_bit_i,
  output logic cs_act_o,
  output logic byte_vld_o,
  output logic [7:0] rx_byte_o
);
  logic [2:0] s1_q; // first sync stage {sclk, din, cs_n}
  logic [2:0] s2_q; // second sync stage
  logic sclk_prev_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sr_q;
  logic [7:0] tx_sr_q;
  logic tx_act_q;
  logic dout_q;
  logic rise;
  logic fall;

  // two flops on every pin; cs_n resets high so no false frame
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 3'h1;
      s2_q <= 3'h1;
      sclk_prev_q <= 1'b0;
    end else if (ce_i) begin
      s1_q <= {sclk_i, din_i, cs_n_i};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[2];
    end
  end

  assign cs_act_o = ~s2_q[0];
  assign rise = cs_act_o & s2_q[2] & ~sclk_prev_q;
  assign fall = cs_act_o & ~s2_q[2] & sclk_prev_q;

  // receive: sample on rising edge, leading zeros skipped while hunting
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_q <= 3'h0;
      rx_sr_q <= 7'h00;
      rx_byte_o <= 8'h00;
      byte_vld_o <= 1'b0;
    end else if (ce_i) begin
      byte_vld_o <= 1'b0;
      if (!cs_act_o) begin
        bit_cnt_q <= 3'h0;
      end else if (rise && !(hunt_i && bit_cnt_q == 3'h0 && !s2_q[1])) begin
        rx_sr_q <= {rx_sr_q[5:0], s2_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (&bit_cnt_q) begin
          rx_byte_o <= {rx_sr_q, s2_q[1]};
          byte_vld_o <= 1'b1;
        end
      end
    end
  end

  // transmit: msb first, changes only on falling edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sr_q <= 8'h00;
      tx_act_q <= 1'b0;
      dout_q <= 1'b1;
    end else if (ce_i) begin
      if (!cs_act_o) begin
        tx_act_q <= 1'b0;
      end else if (tx_load_i) begin
        tx_sr_q <= tx_byte_i;
        tx_act_q <= 1'b1;
      end else if (fall && tx_act_q) begin
        dout_q <= tx_sr_q[7];
        tx_sr_q <= {tx_sr_q[6:0], 1'b0};
      end
      if (!tx_act_q) begin
        dout_q <= idle_bit_i;
      end
    end
  end

  // idle frames show the inverted ready flag; released when deselected
  assign dout_o = tx_act_q ? dout_q : idle_bit_i;
  assign dout_oe_n_o = ~cs_act_o;
endmodule
`default_nettype wire

// ===== rtl/acd_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"
// ****************************************
// status flags and result capture
// ****************************************
module acd_status (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // converter events
  input wire logic res_vld_i,
  input wire logic [19:0] raw_i,
  input wire logic cal_done_i,
  input wire logic gain_ovr_i,
  input wire logic busy_i,
  // decoder events
  input wire logic start_i,
  input wire logic [1:0] kind_i,
  input wire logic [2:0] rate_i,
  input wire logic read_done_i,
  // results
  output logic [7:0] status_o,
  output logic [17:0] result_o
);
  logic gov_q, or_q, ur_q, rdy_q, seen_q;
  logic [2:0] rate_q, pend_rate_q;
  logic hi, lo;

  // headroom bits tell whether the core ran past full scale
  assign hi = $signed(raw_i) > $signed({{2{1'b0}}, `ACD_RES_MAX});
  assign lo = $signed(raw_i) < $signed({{2{1'b1}}, `ACD_RES_MIN});

  // result with clipping and range flags
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      result_o <= 18'h00000;
      or_q <= 1'b0;
      ur_q <= 1'b0;
    end else if (ce_i && res_vld_i) begin
      result_o <= hi ? `ACD_RES_MAX : (lo ? `ACD_RES_MIN : raw_i[17:0]);
      or_q <= hi;
      ur_q <= lo;
    end
  end

  // rate follows the held result or the last calibration
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_q <= 3'h0;
      pend_rate_q <= 3'h0;
    end else if (ce_i) begin
      if (start_i) begin
        pend_rate_q <= rate_i;
      end
      if (res_vld_i || cal_done_i) begin
        rate_q <= pend_rate_q;
      end
    end
  end

  // gain overrange: set wins over the clear at a new gain calibration
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gov_q <= 1'b0;
    end else if (ce_i) begin
      if (gain_ovr_i) begin
        gov_q <= 1'b1;
      end else if (start_i && kind_i == `ACD_KIND_SYSGAIN) begin
        gov_q <= 1'b0;
      end
    end
  end

  // ready: new result wins over every clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (ce_i) begin
      if (res_vld_i) begin
        rdy_q <= 1'b1;
        seen_q <= 1'b0;
      end else if (read_done_i && busy_i) begin
        rdy_q <= 1'b0;
      end else if (read_done_i) begin
        seen_q <= 1'b1;
      end else if (start_i && kind_i == `ACD_KIND_CONV && seen_q) begin
        rdy_q <= 1'b0;
        seen_q <= 1'b0;
      end
    end
  end

  assign status_o = {gov_q, rate_q, or_q, ur_q, busy_i, rdy_q};
endmodule
`default_nettype wire

// ===== rtl/acd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"
// ****************************************
// command decoder and register map
// ****************************************
module acd_decoder #(
  parameter bit HAS_GAIN = 1'b1
) (
  // clock, enable and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  // converter control
  output logic conv_start_o,
  output logic cal_start_o,
  output logic [1:0] cal_kind_o,
  output logic [2:0] rate_o,
  output logic sleep_o,
  // converter status and results
  input wire logic busy_i,
  input wire logic res_vld_i,
  input wire logic [19:0] raw_i,
  input wire logic cal_done_i,
  input wire logic gain_ovr_i,
  // calibration coefficient updates from the core
  input wire logic cal_wr_i,
  input wire logic [3:0] cal_sel_i,
  input wire logic [23:0] cal_val_i,
  // configuration to the rest of the chip
  output logic [7:0] control_one_o,
  output logic [7:0] port_pin_control_o,
  output logic [4:0] trim_ctrl_o,
  output logic [2:0] digital_gain_sel_o,
  output logic [23:0] coeff_o [4]
);
  acd_pkg::acd_state_t state_q;
  logic [3:0] sel_q; // register_select of current access
  logic [1:0] left_q; // bytes still to move, current one included
  logic [15:0] wbuf_q; // earlier bytes of a write
  logic [23:0] rd_word_q; // read snapshot, next byte on top
  logic tx_load_q;
  logic read_done_q;
  logic [7:0] control_one_q, port_pin_control_q, gain_and_trim_control_q;
  logic [23:0] coeff_q [4]; // system zero, system full, chip zero, chip full
  // front end wires
  logic cs_act, byte_vld, hunt;
  logic [7:0] rx_byte;
  logic [7:0] status_w;
  logic [17:0] result_w;
  // decode helpers
  logic cmd_seen, is_mode1, kind_conv, wr_last;
  logic [1:0] kind;
  logic [3:0] rs;
  logic [23:0] wr_word;

  // ****************************************
  // helper functions
  // ****************************************
  // bytes moved for a register, unmapped selects move one byte
  function automatic logic [1:0] reg_len(input logic [3:0] s);
    reg_len = (s >= `ACD_SEL_DATA && s <= `ACD_SEL_CHIP_FULLSCALE_COEFF) ? `ACD_LEN_WIDE : `ACD_LEN_NARROW;
  endfunction

  // coefficient slot of a select code
  function automatic logic [1:0] coeff_idx(input logic [3:0] s);
    logic [3:0] d;
    d = s - `ACD_SEL_SOC;
    coeff_idx = d[1:0];
  endfunction

  // true for the four writable coefficient selects
  function automatic logic is_coeff(input logic [3:0] s);
    is_coeff = (s >= `ACD_SEL_SOC && s <= `ACD_SEL_CHIP_FULLSCALE_COEFF);
  endfunction

  // ****************************************
  // serial front end and status
  // ****************************************
  acd_spi_shift u_shift (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .din_i(din_i),
    .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o),
    .hunt_i(hunt),
    .tx_load_i(tx_load_q),
    .tx_byte_i(rd_word_q[23:16]),
    .idle_bit_i(~status_w[0]),
    .cs_act_o(cs_act),
    .byte_vld_o(byte_vld),
    .rx_byte_o(rx_byte)
  );

  acd_status u_status (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .res_vld_i(res_vld_i),
    .raw_i(raw_i),
    .cal_done_i(cal_done_i),
    .gain_ovr_i(gain_ovr_i),
    .busy_i(busy_i),
    .start_i(conv_start_o | cal_start_o),
    .kind_i(cal_kind_o),
    .rate_i(rate_o),
    .read_done_i(read_done_q),
    .status_o(status_w),
    .result_o(result_w)
  );

  // ****************************************
  // command byte decode
  // ****************************************
  // the start bit only frames the byte; hunting drops leading zeros
  assign hunt = (state_q == acd_pkg::ACD_ST_CMD);
  assign cmd_seen = ce_i && byte_vld && state_q == acd_pkg::ACD_ST_CMD;
  assign is_mode1 = rx_byte[`ACD_CMD_MODE];
  assign kind = rx_byte[`ACD_CMD_KIND_HI:`ACD_CMD_KIND_LO];
  assign kind_conv = (kind == `ACD_KIND_CONV);
  assign rs = rx_byte[`ACD_CMD_RS_HI:`ACD_CMD_RS_LO];
  assign wr_last = ce_i && byte_vld && state_q == acd_pkg::ACD_ST_WRITE && left_q == `ACD_LEN_NARROW;
  assign wr_word = {wbuf_q, rx_byte};

  // operation requests are one-cycle pulses; sleep is held until work resumes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
      cal_start_o <= 1'b0;
      cal_kind_o <= `ACD_KIND_CONV;
      rate_o <= 3'h0;
      sleep_o <= 1'b0;
    end else if (ce_i) begin
      conv_start_o <= 1'b0;
      cal_start_o <= 1'b0;
      if (cmd_seen && !is_mode1) begin
        cal_kind_o <= kind;
        rate_o <= rx_byte[`ACD_CMD_RATE_HI:0];
        if (!kind_conv) begin
          cal_start_o <= 1'b1;
          sleep_o <= 1'b0;
        end else if (rx_byte[`ACD_CMD_SLEEP] && rx_byte[`ACD_CMD_RATE_HI:0] == `ACD_RATE_SLEEP) begin
          sleep_o <= 1'b1;
        end else begin
          conv_start_o <= 1'b1;
          sleep_o <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // transfer sequencing
  // ****************************************
  // a frame may hold several commands; losing chip select abandons the access
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= acd_pkg::ACD_ST_CMD;
      sel_q <= `ACD_SEL_STATUS;
      left_q <= 2'h0;
      wbuf_q <= 16'h0000;
      tx_load_q <= 1'b0;
      read_done_q <= 1'b0;
    end else if (ce_i) begin
      tx_load_q <= 1'b0;
      read_done_q <= 1'b0;
      if (!cs_act) begin
        state_q <= acd_pkg::ACD_ST_CMD;
      end else if (byte_vld) begin
        case (state_q)
          acd_pkg::ACD_ST_CMD: begin
            // pad bit must be zero, otherwise the access is ignored
            if (is_mode1 && !rx_byte[`ACD_CMD_PAD]) begin
              sel_q <= rs;
              left_q <= reg_len(rs);
              if (rx_byte[`ACD_CMD_WR]) begin
                state_q <= acd_pkg::ACD_ST_READ;
                tx_load_q <= 1'b1;
              end else begin
                state_q <= acd_pkg::ACD_ST_WRITE;
              end
            end
          end
          acd_pkg::ACD_ST_READ: begin
            left_q <= left_q - 2'h1;
            if (left_q == `ACD_LEN_NARROW) begin
              state_q <= acd_pkg::ACD_ST_CMD;
              read_done_q <= (sel_q == `ACD_SEL_DATA);
            end else begin
              tx_load_q <= 1'b1;
            end
          end
          acd_pkg::ACD_ST_WRITE: begin
            left_q <= left_q - 2'h1;
            wbuf_q <= {wbuf_q[7:0], rx_byte};
            if (left_q == `ACD_LEN_NARROW) begin
              state_q <= acd_pkg::ACD_ST_CMD;
            end
          end
          default: begin
            state_q <= acd_pkg::ACD_ST_CMD;
          end
        endcase
      end
    end
  end

  // read snapshot: taken at the command so a fresh result cannot tear a read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_word_q <= 24'h000000;
    end else if (ce_i) begin
      if (cmd_seen && is_mode1) begin
        case (rs)
          `ACD_SEL_STATUS: rd_word_q <= {status_w, 16'h0000};
          `ACD_SEL_CONTROL_ONE: rd_word_q <= {control_one_q, 16'h0000};
          `ACD_SEL_PORT_PIN_CONTROL: rd_word_q <= {port_pin_control_q, 16'h0000};
          `ACD_SEL_GAIN_AND_TRIM_CONTROL: rd_word_q <= {gain_and_trim_control_q, 16'h0000};
          `ACD_SEL_DATA: rd_word_q <= {6'h00, result_w};
          default: begin
            rd_word_q <= is_coeff(rs) ? coeff_q[coeff_idx(rs)] : 24'h000000;
          end
        endcase
      end else if (tx_load_q) begin
        rd_word_q <= {rd_word_q[15:0], 8'h00};
      end
    end
  end

  // ****************************************
  // register file
  // ****************************************
  // control registers; status, result and unmapped writes fall through
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      control_one_q <= `ACD_RST_CONTROL_ONE;
      port_pin_control_q <= `ACD_RST_PORT_PIN_CONTROL;
      gain_and_trim_control_q <= `ACD_RST_GAIN_AND_TRIM_CONTROL;
    end else if (ce_i && wr_last) begin
      case (sel_q)
        `ACD_SEL_CONTROL_ONE: control_one_q <= rx_byte;
        `ACD_SEL_PORT_PIN_CONTROL: port_pin_control_q <= rx_byte;
        `ACD_SEL_GAIN_AND_TRIM_CONTROL: gain_and_trim_control_q <= rx_byte;
        default: begin
          control_one_q <= control_one_q;
        end
      endcase
    end
  end

  // coefficients: the core's own update wins over a host write in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        coeff_q[i] <= `ACD_RST_COEFF;
      end
    end else if (ce_i) begin
      if (cal_wr_i && is_coeff(cal_sel_i)) begin
        coeff_q[coeff_idx(cal_sel_i)] <= cal_val_i;
      end else if (wr_last && is_coeff(sel_q)) begin
        coeff_q[coeff_idx(sel_q)] <= wr_word;
      end
    end
  end

  // outputs to the rest of the chip
  assign control_one_o = control_one_q;
  assign port_pin_control_o = port_pin_control_q;
  assign trim_ctrl_o = gain_and_trim_control_q[`ACD_GAIN_LO-1:0];
  // without the gain option the field is stored but has no effect
  assign digital_gain_sel_o = HAS_GAIN ? gain_and_trim_control_q[`ACD_GAIN_HI:`ACD_GAIN_LO] : 3'h0;
  assign coeff_o = coeff_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd0;
    cmd_seen && !is_mode1;
  endsequence

  sequence s_read_cmd;
    cmd_seen && is_mode1 && !rx_byte[`ACD_CMD_PAD] && rx_byte[`ACD_CMD_WR];
  endsequence

  chk_cal_kind_start: assert property ((s_cmd0 and !kind_conv) |=> cal_start_o && cal_kind_o == $past(kind))
    else $error("calibration not started");
  chk_conv_rate_start: assert property ((s_cmd0 and (kind_conv && !rx_byte[`ACD_CMD_SLEEP]))
      |=> conv_start_o && rate_o == $past(rx_byte[`ACD_CMD_RATE_HI:0]))
    else $error("conversion not started at rate");
  chk_sleep_now: assert property ((s_cmd0 and (kind_conv && rx_byte[`ACD_CMD_SLEEP]
      && rx_byte[`ACD_CMD_RATE_HI:0] == `ACD_RATE_SLEEP)) |=> sleep_o && !conv_start_o)
    else $error("sleep not entered");
  chk_read_len: assert property (s_read_cmd |=> state_q == acd_pkg::ACD_ST_READ
      && left_q == reg_len($past(rs)) ##1 tx_load_q == 1'b0)
    else $error("read length wrong");
  chk_control_one_write: assert property (wr_last && sel_q == `ACD_SEL_CONTROL_ONE |=> control_one_q == $past(rx_byte))
    else $error("control one not written");
  chk_ro_write_drop: assert property (wr_last && !is_coeff(sel_q) && sel_q > `ACD_SEL_GAIN_AND_TRIM_CONTROL
      |=> $stable(control_one_q) && $stable(port_pin_control_q) && $stable(gain_and_trim_control_q))
    else $error("read-only write took effect");
  // only a busy-time read in the following cycle may take the fresh flag away again
  chk_rdy_set: assert property (ce_i && res_vld_i |=> status_w[0] ##1 (status_w[0] || $past(ce_i && read_done_q && busy_i)))
    else $error("ready not set");
  chk_rdy_busy_clear: assert property (ce_i && read_done_q && busy_i && !res_vld_i |=> !status_w[0])
    else $error("ready not cleared after read");
  chk_over_clip: assert property (ce_i && res_vld_i && $signed(raw_i) > $signed({2'b00, `ACD_RES_MAX})
      |=> status_w[3] && result_w == `ACD_RES_MAX)
    else $error("overrange not clipped");
  chk_under_clip: assert property (ce_i && res_vld_i && $signed(raw_i) < $signed({2'b11, `ACD_RES_MIN})
      |=> status_w[2] && result_w == `ACD_RES_MIN)
    else $error("underrange not clipped");
  chk_gain_mask: assert property (!HAS_GAIN |-> digital_gain_sel_o == 3'h0)
    else $error("gain field leaked");
endmodule
`default_nettype wire

// ===== testbench/acd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial host model
// ****************************************
module acd_host_model (
  // clock
  input wire logic mclk_i,
  // pins
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // idle: deselected, clock parked low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // all pin moves happen on falling system clock edges
  task automatic gap(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // one byte msb first, 80 ns serial period; caller keeps start bit set
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din_o = tx[i];
      gap(4);
      sclk_o = 1'b1;
      rx[i] = dout_i;
      gap(4);
      sclk_o = 1'b0;
    end
  endtask
  // open or close a frame; a released data line shows the inverse level
  task automatic frame(input logic on);
    if (on) begin
      cs_n_o = 1'b0;
      gap(4);
    end else begin
      gap(4);
      cs_n_o = 1'b1;
      din_o = ~din_o;
      gap(6);
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/acd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// decoder testbench
// ****************************************
module acd_decoder_tb;
  logic mclk = 0, rst = 1, ce = 1, busy = 0, res_vld = 0, cal_done = 0, gain_ovr = 0, cal_wr = 0;
  logic [4:0] trim;
  logic [19:0] raw = '0;
  logic [3:0] cal_sel = 4'h0;
  logic [23:0] cal_val = 24'h0, v, coeff [4];
  logic cs_n, sclk, din, dout, oe_n, conv_st, cal_st, sleep;
  logic [1:0] kind;
  logic [2:0] rate, dgain, dgain0;
  logic [7:0] c1, c2;
  int n_fail = 0, samples_checked = 0, n_conv = 0, n_cal = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  acd_decoder #(.HAS_GAIN(1'b1)) u_dut (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_n_o(oe_n), .conv_start_o(conv_st),
    .cal_start_o(cal_st), .cal_kind_o(kind), .rate_o(rate), .sleep_o(sleep), .busy_i(busy),
    .res_vld_i(res_vld), .raw_i(raw), .cal_done_i(cal_done), .gain_ovr_i(gain_ovr), .cal_wr_i(cal_wr),
    .cal_sel_i(cal_sel), .cal_val_i(cal_val), .control_one_o(c1), .port_pin_control_o(c2),
    .trim_ctrl_o(trim), .digital_gain_sel_o(dgain), .coeff_o(coeff));
  // copy without the gain option on the same traffic; only its gain field is watched
  acd_decoder #(.HAS_GAIN(1'b0)) u_nogain (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(), .dout_oe_n_o(), .conv_start_o(), .cal_start_o(), .cal_kind_o(),
    .rate_o(), .sleep_o(), .busy_i(busy), .res_vld_i(res_vld), .raw_i(raw), .cal_done_i(cal_done),
    .gain_ovr_i(gain_ovr), .cal_wr_i(cal_wr), .cal_sel_i(cal_sel), .cal_val_i(cal_val), .control_one_o(),
    .port_pin_control_o(), .trim_ctrl_o(), .digital_gain_sel_o(dgain0), .coeff_o());
  // an undriven data pin reads inverted, so a bit taken outside the driven window shows up
  acd_host_model u_host (.mclk_i(mclk), .dout_i(oe_n ? ~dout : dout), .cs_n_o(cs_n), .sclk_o(sclk),
    .din_o(din));
  // count start pulses; one-cycle pulses are only visible at the edge
  always @(posedge mclk) begin
    if (conv_st === 1'b1) n_conv++;
    if (cal_st === 1'b1) n_cal++;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one register access in its own frame; wide selects carry three bytes
  task automatic acc(input logic [3:0] s, input logic w, input logic [23:0] d, output logic [23:0] q);
    logic [7:0] b;
    int n;
    n = (s >= 4'h4 && s <= 4'h8) ? 3 : 1;
    q = '0;
    u_host.frame(1'b1);
    chk({23'h0, oe_n}, 24'h0);
    u_host.xfer({3'b110, s, ~w}, b);
    for (int i = n - 1; i >= 0; i--) begin
      u_host.xfer(d[8*i +: 8], b);
      q = {q[15:0], b};
    end
    u_host.frame(1'b0);
    chk({23'h0, oe_n}, 24'h1);
  endtask
  task automatic rd(input logic [3:0] s, input logic [23:0] e);
    acc(s, 1'b0, 24'h0, v);
    chk(v, e);
  endtask
  task automatic cmd(input logic [7:0] b);
    logic [7:0] x;
    u_host.frame(1'b1);
    u_host.xfer(b, x);
    u_host.frame(1'b0);
  endtask
  task automatic res(input logic [19:0] r);
    raw = r;
    res_vld = 1'b1;
    @(negedge mclk);
    res_vld = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_reset();
    for (int s = 0; s < 10; s++) begin
      rd(s[3:0], s == 1 ? 24'h2 : s == 2 ? 24'hf : s == 3 ? 24'h1e : 24'h0);
    end
    $display("reset values done");
  endtask
  task automatic t_regs();
    acc(4'h1, 1'b1, 24'h5a, v);
    acc(4'h3, 1'b1, 24'he1, v);
    acc(4'h6, 1'b1, 24'h123456, v);
    acc(4'h0, 1'b1, 24'hff, v);
    acc(4'h4, 1'b1, 24'hffffff, v);
    acc(4'h9, 1'b1, 24'h77, v);
    rd(4'h1, 24'h5a);
    rd(4'h3, 24'he1);
    rd(4'h6, 24'h123456);
    rd(4'h0, 24'h0);
    rd(4'h4, 24'h0);
    rd(4'h9, 24'h0);
    chk({16'h0, c1}, 24'h5a);
    chk({21'h0, dgain}, 24'h7);
    chk({21'h0, dgain0}, 24'h0);
    chk({19'h0, trim}, 24'h01);
    chk({16'h0, c2}, 24'hf);
    cal_sel = 4'h8;
    cal_val = 24'habcdef;
    cal_wr = 1'b1;
    @(negedge mclk);
    cal_wr = 1'b0;
    @(negedge mclk);
    chk(coeff[3], 24'habcdef);
    chk(coeff[1], 24'h123456);
    $display("register access done");
  endtask
  task automatic t_cmds();
    for (int r = 0; r < 8; r++) begin
      cmd({5'b10000, r[2:0]});
      chk(24'(n_conv), 24'(r + 1));
      chk({21'h0, rate}, 24'(r));
    end
    cmd(8'h88);
    chk({23'h0, sleep}, 24'h1);
    chk(24'(n_conv), 24'h8);
    for (int k = 1; k < 4; k++) begin
      cmd({2'b10, k[1:0], 4'h0});
      chk(24'(n_cal), 24'(k));
      chk({22'h0, kind}, 24'(k));
    end
    chk({23'h0, sleep}, 24'h0);
    $display("commands done");
  endtask
  task automatic t_result();
    cmd(8'h85);
    busy = 1'b1;
    rd(4'h0, 24'h02);
    busy = 1'b0;
    res(20'h00123);
    rd(4'h0, 24'h51);
    rd(4'h4, 24'h000123);
    rd(4'h0, 24'h51);
    cmd(8'h82);
    rd(4'h0, 24'h50);
    res(20'h3ffff);
    rd(4'h0, 24'h29);
    cmd(8'h82);
    rd(4'h0, 24'h29);
    busy = 1'b1;
    rd(4'h4, 24'h01ffff);
    rd(4'h0, 24'h2a);
    busy = 1'b0;
    res(20'hc0000);
    rd(4'h4, 24'h020000);
    rd(4'h0, 24'h25);
    cmd(8'hb0);
    gain_ovr = 1'b1;
    cal_done = 1'b1;
    @(negedge mclk);
    gain_ovr = 1'b0;
    cal_done = 1'b0;
    rd(4'h0, 24'h85);
    // clock enable low: a result offered meanwhile must leave no trace
    ce = 1'b0;
    res(20'h00001);
    ce = 1'b1;
    rd(4'h4, 24'h020000);
    rd(4'h0, 24'h85);
    $display("status and result done");
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_regs();
    t_cmds();
    t_result();
    summarize();
  end
  // watchdog: the run needs well under half of this span
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
